/* design/relay_port.sv */
// Isolated input and relay output port
`timescale 1ns/1ps
`include "relay_port_map.svh"

module relay_port #(
	parameter int TAU_CYCLES = `FILTER_TAU_CYCLES
) (
	// Clock and reset
	input  wire logic                       sys_clk_in,
	input  wire logic                       nrst_in,
	// Relay control port
	input  wire logic                       relay_wr_in,
	input  wire logic [7:0]                 relay_wdata_in,
	output logic      [7:0]                 relay_rdata_out,
	// Filter control
	input  wire logic                       filter_wr_in,
	input  wire logic [7:0]                 filter_wdata_in,
	output logic      [7:0]                 filter_en_out,
	// Field inputs and readback
	input  wire logic [7:0]                 field_in,
	output logic      [7:0]                 input_byte_out,
	// Relay coil drives and contact state
	output logic      [7:0]                 coil_out,
	output relay_port_pkg::contacts_s       contacts_out
);
	localparam int CW = $clog2(TAU_CYCLES + 1);
	localparam logic [CW-1:0] TAU_MAX = CW'(TAU_CYCLES);

	logic [7:0] relay;
	logic [7:0] filt_en;
	logic [7:0] sync1;
	logic [7:0] sync2;
	logic [7:0] filt_state;
	logic [CW-1:0] cnt [8];

	// Coils drive straight from the register: contact travel dwarfs one clock
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			relay <= `RELAY_RESET_VALUE;
		end else if (relay_wr_in) begin
			relay <= relay_wdata_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			filt_en <= `FILTER_RESET_VALUE;
		end else if (filter_wr_in) begin
			filt_en <= filter_wdata_in;
		end
	end

	// Field inputs are asynchronous to the bus clock
	// Input pulses shorter than one clock can be missed
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1 <= 8'h00;
			sync2 <= 8'h00;
		end else begin
			sync1 <= field_in;
			sync2 <= sync1;
		end
	end

	// Integrating counter approximates the RC: output flips only after the
	// input has dominated for about one time constant, which rejects AC ripple
	genvar g;
	generate
		for (g = 0; g < `RELAY_CHANNELS; g++) begin : g_filt
			always_ff @(posedge sys_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					cnt[g]        <= '0;
					filt_state[g] <= 1'b0;
				end else if (!filt_en[g]) begin
					cnt[g]        <= sync2[g] ? TAU_MAX : '0;
					filt_state[g] <= sync2[g];
				end else if (sync2[g] && cnt[g] != TAU_MAX) begin
					cnt[g] <= cnt[g] + 1'b1;
				end else if (!sync2[g] && cnt[g] != '0) begin
					cnt[g] <= cnt[g] - 1'b1;
				end else begin
					filt_state[g] <= sync2[g];
				end
			end

			// Per channel: count stays in range, with the filter on the output moves only from a saturated counter, with it off the count loads
			property p_cnt_range;
				@(posedge sys_clk_in) disable iff (!nrst_in)
				cnt[g] <= TAU_MAX;
			endproperty
			a_cnt_range: assert property (p_cnt_range) else $error("filter count overrun");

			property p_filt_pass;
				@(posedge sys_clk_in) disable iff (!nrst_in)
				$past(filt_en[g]) && $changed(filt_state[g])
					|-> $past(cnt[g]) == (filt_state[g] ? TAU_MAX : '0);
			endproperty
			a_filt_pass: assert property (p_filt_pass) else $error("filter moved early");

			property p_off_load;
				@(posedge sys_clk_in) disable iff (!nrst_in)
				!filt_en[g] |=> cnt[g] == ($past(sync2[g]) ? TAU_MAX : '0);
			endproperty
			a_off_load: assert property (p_off_load) else $error("filter count not loaded");
		end
	endgenerate

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			input_byte_out <= 8'h00;
		end else begin
			input_byte_out <= filt_state;
		end
	end

	assign relay_rdata_out = relay;
	assign filter_en_out = filt_en;
	assign coil_out = relay;
	// Make-only relays have no NC contact, so their to_nc stays low
	always_comb begin
		contacts_out.to_no = relay;
		contacts_out.to_nc = 8'h00;
		for (int i = 0; i <= `CHANGEOVER_LAST; i++) begin
			contacts_out.to_nc[i] = ~relay[i];
		end
	end

	property p_wr_relay;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		relay_wr_in |=> relay_rdata_out == $past(relay_wdata_in);
	endproperty
	a_wr_relay: assert property (p_wr_relay) else $error("relay readback wrong");

	property p_changeover;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		contacts_out.to_nc[4:0] == ~coil_out[4:0] && contacts_out.to_no == coil_out;
	endproperty
	a_changeover: assert property (p_changeover) else $error("changeover contact wrong");

	property p_make_only;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		contacts_out.to_nc[7:5] == 3'h0;
	endproperty
	a_make_only: assert property (p_make_only) else $error("make-only relay has NC");

	property p_hold;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		!relay_wr_in |=> $stable(relay_rdata_out);
	endproperty
	a_hold: assert property (p_hold) else $error("relay changed without write");

	property p_unfilt;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		(filt_en == 8'h00) [*4] |-> input_byte_out == $past(sync2, 2);
	endproperty
	a_unfilt: assert property (p_unfilt) else $error("unfiltered input wrong");

	property p_filt_hold;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		filt_en[0] && cnt[0] != TAU_MAX && cnt[0] != '0 |=> $stable(filt_state[0]);
	endproperty
	a_filt_hold: assert property (p_filt_hold) else $error("filter passed glitch");

	property p_filt_wr;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		filter_wr_in |=> filter_en_out == $past(filter_wdata_in);
	endproperty
	a_filt_wr: assert property (p_filt_wr) else $error("filter enable wrong");

	property p_coil;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		relay_wr_in |=> coil_out == $past(relay_wdata_in);
	endproperty
	a_coil: assert property (p_coil) else $error("coil mismatch");

	property p_reset;
		@(posedge sys_clk_in) $rose(nrst_in) |-> coil_out == 8'h00 && filter_en_out == 8'h00;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

	property p_nc_rest;
		@(posedge sys_clk_in)
		$rose(nrst_in) |-> contacts_out.to_nc == 8'h1f && contacts_out.to_no == 8'h00;
	endproperty
	a_nc_rest: assert property (p_nc_rest) else $error("relay not at rest after reset");

	property p_in_rest;
		@(posedge sys_clk_in) $rose(nrst_in) |-> input_byte_out == 8'h00;
	endproperty
	a_in_rest: assert property (p_in_rest) else $error("input byte not clear");

	property p_to_no_wr;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		relay_wr_in |=> contacts_out.to_no == $past(relay_wdata_in);
	endproperty
	a_to_no_wr: assert property (p_to_no_wr) else $error("NO contact not following");

	property p_to_nc_wr;
		@(posedge sys_clk_in) disable iff (!nrst_in)
		relay_wr_in |=> contacts_out.to_nc[4:0] == ~$past(relay_wdata_in[4:0]);
	endproperty
	a_to_nc_wr: assert property (p_to_nc_wr) else $error("NC contact not following");

	c_write: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) relay_wr_in);
	c_filt: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
		filt_en[0] && $rose(filt_state[0]));
	c_in: cover property (@(posedge sys_clk_in) disable iff (!nrst_in) $changed(input_byte_out));
	c_reject: cover property (@(posedge sys_clk_in) disable iff (!nrst_in)
		filt_en[0] && filt_state[0] && !sync2[0]);
	c_reset: cover property (@(posedge sys_clk_in) $rose(nrst_in));
endmodule

/* include/relay_port_map.svh */
// Constants for the isolated input and relay output port
`ifndef RELAY_PORT_MAP_SVH
`define RELAY_PORT_MAP_SVH
`define RELAY_CHANNELS      8
`define CHANGEOVER_LAST     4
`define RELAY_RESET_VALUE   8'h00
`define FILTER_RESET_VALUE  8'h00
`define FILTER_TAU_US       5000
`define CLOCK_PERIOD_NS     20
`define FILTER_TAU_CYCLES   ((`FILTER_TAU_US * 1000) / `CLOCK_PERIOD_NS)
`endif

/* include/relay_port_pkg.sv */
// Types for the isolated input and relay output port
package relay_port_pkg;
	typedef struct packed {
		logic [7:0] to_no;
		logic [7:0] to_nc;
	} contacts_s;
endpackage

/* tb/field_side.sv */
// Field side model: sensor levels on the isolated inputs
`timescale 1ns/1ps
module field_side (
	// Levels chosen by the bench
	input  wire logic [7:0] level_in,
	// Isolated inputs of the port
	output logic      [7:0] field_out
);
	// Rectified inputs: only on or off reaches the port
	assign field_out = level_in;
endmodule

/* tb/tb.sv */
// Self-checking bench for the relay port
`timescale 1ns/1ps
module tb;
	logic                      sys_clk_in      = 1'b0;
	logic                      nrst_in         = 1'b0;
	logic                      relay_wr_in     = 1'b0;
	logic [7:0]                relay_wdata_in  = 8'h00;
	logic                      filter_wr_in    = 1'b0;
	logic [7:0]                filter_wdata_in = 8'h00;
	logic [7:0]                level           = 8'h00;
	logic [7:0]                field;
	logic [7:0]                rdata;
	logic [7:0]                fen;
	logic [7:0]                inb;
	logic [7:0]                coil;
	relay_port_pkg::contacts_s ct;
	logic [7:0]                pat[4]          = '{8'h21, 8'hff, 8'h00, 8'ha5};
	int                        errors          = 0;
	int                        samples_checked = 0;
	int                        n;
	always #10 sys_clk_in = ~sys_clk_in;
	field_side i_field (.level_in(level), .field_out(field));
	// Short filter so the run stays brief
	localparam int TAU = 8;
	relay_port #(.TAU_CYCLES(TAU)) i_dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.relay_wr_in(relay_wr_in), .relay_wdata_in(relay_wdata_in), .relay_rdata_out(rdata),
		.filter_wr_in(filter_wr_in), .filter_wdata_in(filter_wdata_in), .filter_en_out(fen),
		.field_in(field), .input_byte_out(inb), .coil_out(coil), .contacts_out(ct));
	task automatic test_done();
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic wr_filter(input logic [7:0] d);
		filter_wr_in = 1'b1;
		filter_wdata_in = d;
		tick(1);
		filter_wr_in = 1'b0;
	endtask
	initial begin
		tick(4);
		chk(coil, 8'h00);
		chk(ct.to_nc, 8'h1f);
		chk(fen, 8'h00);
		nrst_in = 1'b1;
		tick(1);
		// Strobe held high so the writes run back to back
		relay_wr_in = 1'b1;
		foreach (pat[i]) begin
			relay_wdata_in = pat[i];
			tick(1);
			chk(rdata, pat[i]);
			chk(coil, pat[i]);
			chk(ct.to_no, pat[i]);
			chk(ct.to_nc, ~pat[i] & 8'h1f);
		end
		relay_wr_in = 1'b0;
		level = 8'h5a;
		tick(4);
		chk(inb, 8'h5a);
		wr_filter(8'h81);
		chk(fen, 8'h81);
		level = 8'ha5;
		tick(4);
		chk(inb, 8'h24);
		n = 0;
		while (inb !== 8'ha5 && n < 40) begin
			tick(1);
			n++;
		end
		if (n >= 40) begin
			errors++;
			$display("unexpected at %0t: filtered input never settled", $time);
			test_done();
		end
		chk(inb, 8'ha5);
		chk(8'(n), 8'(TAU));
		// Short dip on a filtered input must not reach the byte
		level = 8'ha4;
		tick(3);
		level = 8'ha5;
		tick(2);
		chk(inb, 8'ha5);
		wr_filter(8'h00);
		level = 8'h0f;
		tick(4);
		chk(inb, 8'h0f);
		// Reset in mid-run must clear relays and filters that were set
		relay_wr_in = 1'b1;
		relay_wdata_in = 8'hff;
		wr_filter(8'hff);
		relay_wr_in = 1'b0;
		chk(rdata, 8'hff);
		chk(fen, 8'hff);
		nrst_in = 1'b0;
		tick(1);
		chk(coil, 8'h00);
		chk(ct.to_nc, 8'h1f);
		chk(fen, 8'h00);
		chk(inb, 8'h00);
		nrst_in = 1'b1;
		level = 8'hf0;
		tick(4);
		chk(inb, 8'hf0);
		test_done();
	end
endmodule
